// *** dv/testbench.sv ***
// Self-checking bench for the buffer event flag block over AXI4-Lite
`timescale 1ns/1ps
`include "buffer_event_defs.svh"

module testbench;
    import buffer_event_pkg::*;

    logic               clk_sys = 1'b0;
    logic               resetn;
    logic [11:0]        awaddr, araddr;
    logic               awvalid, wvalid, bready, arvalid, rready;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]         bresp, rresp;
    logic [31:0]        rdata;
    logic [2:0][3:0]    ev;
    logic [3:0]         no_space, no_data;
    count_t [3:0]       quadlet_count;
    int                 bad_count, comparisons;
    logic [31:0]        d;
    logic [1:0]         r;
    int                 b, k;
    count_t             t;

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    data_buffer_event_flags uut (
        .clk_sys(clk_sys), .resetn(resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cell_confirm(ev[0]), .stamp_release(ev[1]), .stamp_expire(ev[2]),
        .no_space(no_space), .no_data(no_data), .quadlet_count(quadlet_count),
        .irq(irq)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task end_of_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Address and data offered together, each dropped once taken
    task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge clk_sys);
        awaddr <= a; wdata <= v; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (bvalid !== 1'b1) @(posedge clk_sys);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_sys);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // One-cycle event pulse on buffer bb of kind kk
    task pulse(input int kk, input int bb);
        @(posedge clk_sys);
        ev[kk][bb] <= 1'b1;
        @(posedge clk_sys);
        ev[kk][bb] <= 1'b0;
    endtask

    function automatic logic [31:0] bit_of(input int bb, input int pos);
        return 32'h0000_0001 << (8 * bb + pos);
    endfunction

    // Generous bound: each test step takes only tens of cycles
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0; awaddr = 12'h000; araddr = 12'h000; awvalid = 1'b0;
        wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        wdata = 32'h0; wstrb = 4'h0; ev = '0; no_space = 4'h0; no_data = 4'h0;
        quadlet_count = '0; bad_count = 0; comparisons = 0;
        void'($urandom(32'h7A95));
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset value, then clear on read, then writes ignored
        rd(`FLAGS_OFF, d, r); chk(d, `FLAGS_RST);
        rd(`FLAGS_OFF, d, r); chk(d, 32'h0);
        wr(`FLAGS_OFF, 32'hFFFF_FFFF, r); chk(r, `RESP_OKAY);
        rd(`FLAGS_OFF, d, r); chk(d, 32'h0);
        rd(12'h000, d, r);
        chk(d, 32'h0);
        chk(r, `RESP_SLVERR);
        // Random pulse events land in their own lane bit
        for (int i = 0; i < 24; i++) begin
            b = $urandom % 4; k = $urandom % 3;
            pulse(k, b);
            rd(`FLAGS_OFF, d, r); chk(d, bit_of(b, 7 - k));
        end
        // Level flags keep re-setting while held, set beats the clearing read
        for (b = 0; b < 4; b++) begin
            no_space[b] <= 1'b1; no_data[b] <= 1'b1;
            rd(`FLAGS_OFF, d, r);
            rd(`FLAGS_OFF, d, r); chk(d, bit_of(b, 1) | bit_of(b, 0));
            no_space[b] <= 1'b0; no_data[b] <= 1'b0;
            rd(`FLAGS_OFF, d, r);
            rd(`FLAGS_OFF, d, r); chk(d, 32'h0);
        end
        // Level marks: hi above threshold, lo below, rising edge only
        for (b = 0; b < 4; b++) begin
            t = count_t'($urandom % 4000 + 1);
            quadlet_count[b] <= t;
            wr(`MARK_CFG_OFF + 12'(4 * b), {6'h0, 2'b10, t, t}, r);
            quadlet_count[b] <= t + 12'h001;
            rd(`FLAGS_OFF, d, r); chk(d, bit_of(b, 4));
            rd(`FLAGS_OFF, d, r); chk(d, 32'h0);
            quadlet_count[b] <= t - 12'h001;
            rd(`FLAGS_OFF, d, r); chk(d, bit_of(b, 3));
            rd(`FLAGS_OFF, d, r);
        end
        // Every count now sits just below its threshold: lo marks high only
        rd(`LEVEL_STATE_OFF, d, r);
        chk(d, 32'h0000_0055);
        // Buffer 2 empty is enabled from reset, so the held level raised bit 1
        rd(`IRQ_STAT_OFF, d, r);
        chk(d, 32'h2);
        wr(`ENABLE_OFF, 32'hFFFF_FFFF, r);
        rd(`ENABLE_OFF, d, r);
        chk(d, `ENABLE_VALID);
        // Summary interrupt: enabled, masked in, cleared, then disabled
        wr(`IRQ_STAT_OFF, 32'h3, r);
        wr(`IRQ_MASK_OFF, 32'h3, r);
        wr(`ENABLE_OFF, 32'h8000_0080, r);
        rd(`ENABLE_OFF, d, r); chk(d, 32'h8000_0080);
        pulse(0, 0);
        repeat (2) @(posedge clk_sys);
        chk(irq, 1'b1);
        rd(`IRQ_STAT_OFF, d, r); chk(d, 32'h1);
        wr(`IRQ_STAT_OFF, 32'h1, r);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        pulse(0, 3);
        repeat (2) @(posedge clk_sys);
        rd(`IRQ_STAT_OFF, d, r);
        chk(d, 32'h2);
        chk(irq, 1'b1);
        wr(`IRQ_STAT_OFF, 32'h2, r);
        pulse(0, 1);
        pulse(1, 2);
        repeat (2) @(posedge clk_sys);
        rd(`IRQ_STAT_OFF, d, r);
        chk(d, 32'h0);
        chk(irq, 1'b0);
        // Cell flags of buffers 0, 1 and 3 and the release flag of buffer 2 were never read, so they still stand
        rd(`FLAGS_OFF, d, r);
        chk(d, bit_of(0, 7) | bit_of(1, 7) | bit_of(2, 6) | bit_of(3, 7));
        end_of_test();
    end
endmodule

// *** logic/buffer_event_defs.svh ***
// Register offsets, field positions, reset values and masks of the buffer event block
`ifndef BUFFER_EVENT_DEFS_SVH
`define BUFFER_EVENT_DEFS_SVH

// Register byte addresses on the register bus
`define ADDR_W           12
`define FLAGS_OFF        12'h14C
`define ENABLE_OFF       12'h150
`define IRQ_STAT_OFF     12'h154
`define IRQ_MASK_OFF     12'h158
`define LEVEL_STATE_OFF  12'h15C
`define MARK_CFG_OFF     12'h160

// Geometry
`define NUM_BUF          4
`define LANE_W           8
`define COUNT_W          12

// Bit positions within one buffer lane
`define BIT_CELL         3'h7
`define BIT_RELEASE      3'h6
`define BIT_EXPIRE       3'h5
`define BIT_MARK_HI      3'h4
`define BIT_MARK_LO      3'h3
`define BIT_RSVD         3'h2
`define BIT_FULL         3'h1
`define BIT_EMPTY        3'h0

// Field positions of a level mark configuration word
`define MARK_LO_THR_LSB  0
`define MARK_HI_THR_LSB  12
`define MARK_LO_ABOVE    24
`define MARK_HI_ABOVE    25

// Reset values and valid-bit masks
`define FLAGS_RST        32'h0001_0000
`define ENABLE_RST       32'h0001_0000
`define MARK_CFG_RST     32'h0000_0000
`define LANE_VALID       8'hFB
`define ENABLE_VALID     32'hFBFB_FBFB
`define MARK_CFG_VALID   32'h03FF_FFFF

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// *** logic/buffer_event_pkg.sv ***
// Types shared by the buffer event flag block
package buffer_event_pkg;

    typedef logic [11:0] count_t;
    typedef logic [7:0]  lane_t;

    typedef enum logic [2:0] {
        SEL_FLAGS,
        SEL_ENABLE,
        SEL_IRQ_STAT,
        SEL_IRQ_MASK,
        SEL_LEVEL_STATE,
        SEL_MARK_CFG,
        SEL_NONE
    } reg_sel_t;

endpackage

// *** logic/data_buffer_event_flags.sv ***
// Data buffer event flag register with AXI4-Lite access and summary interrupt
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "buffer_event_defs.svh"

module data_buffer_event_flags (
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    // AXI4-Lite write address
    input  wire logic [11:0]                    awaddr,
    input  wire logic                           awvalid,
    output logic                                awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                    wdata,
    input  wire logic [3:0]                     wstrb,
    input  wire logic                           wvalid,
    output logic                                wready,
    // AXI4-Lite write response
    output logic [1:0]                          bresp,
    output logic                                bvalid,
    input  wire logic                           bready,
    // AXI4-Lite read address
    input  wire logic [11:0]                    araddr,
    input  wire logic                           arvalid,
    output logic                                arready,
    // AXI4-Lite read data
    output logic [31:0]                         rdata,
    output logic [1:0]                          rresp,
    output logic                                rvalid,
    input  wire logic                           rready,
    // Buffer datapath events, same clock domain
    input  wire logic [3:0]                     cell_confirm,
    input  wire logic [3:0]                     stamp_release,
    input  wire logic [3:0]                     stamp_expire,
    input  wire logic [3:0]                     no_space,
    input  wire logic [3:0]                     no_data,
    input  wire buffer_event_pkg::count_t [3:0] quadlet_count,
    // Summary interrupt
    output logic                                irq
);
    import buffer_event_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    localparam logic [31:0] FLAGS_RESET = `FLAGS_RST;

    // Address decode shared by the write and read paths
    function automatic reg_sel_t decode_reg(input logic [`ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr == `FLAGS_OFF) begin
            sel = SEL_FLAGS;
        end else if (addr == `ENABLE_OFF) begin
            sel = SEL_ENABLE;
        end else if (addr == `IRQ_STAT_OFF) begin
            sel = SEL_IRQ_STAT;
        end else if (addr == `IRQ_MASK_OFF) begin
            sel = SEL_IRQ_MASK;
        end else if (addr == `LEVEL_STATE_OFF) begin
            sel = SEL_LEVEL_STATE;
        end else if ((addr & 12'hFF3) == `MARK_CFG_OFF) begin
            sel = SEL_MARK_CFG;
        end
        return sel;
    endfunction

    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] apply_strb(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Write channel state
    logic                 aw_held_q;
    logic                 aw_held_d;
    logic [`ADDR_W-1:0]   aw_addr_q;
    logic [`ADDR_W-1:0]   aw_addr_d;
    logic                 w_held_q;
    logic                 w_held_d;
    logic [31:0]          w_data_q;
    logic [31:0]          w_data_d;
    logic [3:0]           w_strb_q;
    logic [3:0]           w_strb_d;
    logic                 awready_q;
    logic                 awready_d;
    logic                 wready_q;
    logic                 wready_d;
    logic                 bvalid_q;
    logic                 bvalid_d;
    logic [1:0]           bresp_q;
    logic [1:0]           bresp_d;
    logic                 aw_take;
    logic                 w_take;
    logic                 wr_fire;
    reg_sel_t             wr_sel;

    // Read channel state
    logic                 arready_q;
    logic                 arready_d;
    logic                 rvalid_q;
    logic                 rvalid_d;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic [1:0]           rresp_q;
    logic [1:0]           rresp_d;
    logic                 ar_take;
    reg_sel_t             rd_sel;
    logic [31:0]          rd_word;
    logic                 flags_read_clear;

    // Software configuration
    logic [31:0]          enables_q;
    logic [31:0]          enables_d;
    logic [31:0]          mark_cfg_q [`NUM_BUF];
    logic [31:0]          mark_cfg_d [`NUM_BUF];
    logic                 stat_write;
    logic                 mask_write;

    // Lane and summary results
    logic [31:0]          flags_word;
    logic [31:0]          hw_sets;
    logic [7:0]           level_state;
    logic [1:0]           irq_status;
    logic [1:0]           irq_mask;

    // Address and data are taken separately; the write fires once both are
    // held and no response is pending, so a stalled bready blocks new writes.
    always_comb begin
        aw_take   = awvalid & awready_q;
        w_take    = wvalid & wready_q;
        wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
        wr_sel    = decode_reg(aw_addr_q);
        aw_held_d = (aw_held_q & ~wr_fire) | aw_take;
        w_held_d  = (w_held_q & ~wr_fire) | w_take;
        aw_addr_d = aw_take ? awaddr : aw_addr_q;
        w_data_d  = w_take ? wdata : w_data_q;
        w_strb_d  = w_take ? wstrb : w_strb_q;
        awready_d = ~aw_held_d;
        wready_d  = ~w_held_d;
        bvalid_d  = wr_fire | (bvalid_q & ~bready);
        bresp_d   = bresp_q;
        if (wr_fire) begin
            bresp_d = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    // Configuration writes; the flag word itself ignores writes
    always_comb begin
        enables_d = enables_q;
        for (int n = 0; n < `NUM_BUF; n++) begin
            mark_cfg_d[n] = mark_cfg_q[n];
        end
        if (wr_fire && wr_sel == SEL_ENABLE) begin
            enables_d = apply_strb(enables_q, w_data_q, w_strb_q) & `ENABLE_VALID;
        end
        if (wr_fire && wr_sel == SEL_MARK_CFG) begin
            mark_cfg_d[aw_addr_q[3:2]] = apply_strb(mark_cfg_q[aw_addr_q[3:2]], w_data_q,
                                                    w_strb_q) & `MARK_CFG_VALID;
        end
        stat_write = wr_fire && (wr_sel == SEL_IRQ_STAT) && w_strb_q[0];
        mask_write = wr_fire && (wr_sel == SEL_IRQ_MASK) && w_strb_q[0];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enables_q <= `ENABLE_RST;
            for (int n = 0; n < `NUM_BUF; n++) begin
                mark_cfg_q[n] <= `MARK_CFG_RST;
            end
        end else begin
            enables_q <= enables_d;
            for (int n = 0; n < `NUM_BUF; n++) begin
                mark_cfg_q[n] <= mark_cfg_d[n];
            end
        end
    end

    // Read path; data is captured at the address handshake, which is also
    // the moment the flag word clears, so software sees what it cleared.
    always_comb begin
        ar_take = arvalid & arready_q;
        rd_sel  = decode_reg(araddr);
        case (rd_sel)
            SEL_FLAGS:       rd_word = flags_word;
            SEL_ENABLE:      rd_word = enables_q;
            SEL_IRQ_STAT:    rd_word = {30'h0000_0000, irq_status};
            SEL_IRQ_MASK:    rd_word = {30'h0000_0000, irq_mask};
            SEL_LEVEL_STATE: rd_word = {24'h00_0000, level_state};
            SEL_MARK_CFG:    rd_word = mark_cfg_q[araddr[3:2]];
            default:         rd_word = 32'h0000_0000;
        endcase
        flags_read_clear = ar_take && (rd_sel == SEL_FLAGS);
        rvalid_d  = ar_take | (rvalid_q & ~rready);
        arready_d = ~rvalid_d;
        rdata_d   = ar_take ? rd_word : rdata_q;
        rresp_d   = rresp_q;
        if (ar_take) begin
            rresp_d = (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // One flag lane per buffer, packed buffer n at bits 8n+7..8n
    for (genvar g = 0; g < `NUM_BUF; g++) begin : g_lane
        lane_event_flags #(
            .RESET_VAL (FLAGS_RESET[g*8 +: 8])
        ) u_lane (
            .clk_sys        (clk_sys),
            .resetn         (resetn),
            .cell_confirm   (cell_confirm[g]),
            .stamp_release  (stamp_release[g]),
            .stamp_expire   (stamp_expire[g]),
            .no_space       (no_space[g]),
            .no_data        (no_data[g]),
            .quadlet_count  (quadlet_count[g]),
            .mark_lo_thresh (mark_cfg_q[g][`MARK_LO_THR_LSB +: `COUNT_W]),
            .mark_hi_thresh (mark_cfg_q[g][`MARK_HI_THR_LSB +: `COUNT_W]),
            .mark_lo_above  (mark_cfg_q[g][`MARK_LO_ABOVE]),
            .mark_hi_above  (mark_cfg_q[g][`MARK_HI_ABOVE]),
            .read_clear     (flags_read_clear),
            .flags          (flags_word[g*8 +: 8]),
            .hw_sets        (hw_sets[g*8 +: 8]),
            .mark_state     (level_state[g*2 +: 2])
        );
    end

    // Summary bits gather enabled hardware sets into one interrupt line
    irq_summary u_irq (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .hw_sets    (hw_sets),
        .enables    (enables_q),
        .stat_write (stat_write),
        .mask_write (mask_write),
        .write_bits (w_data_q[1:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    a_write_answer: assert property (
        wr_fire |=> bvalid_q)
        else $error("write fired without a response");
    a_read_hold: assert property (
        (rvalid_q && !rready) |=> (rvalid_q && $stable(rdata_q)))
        else $error("read data dropped before rready");
    a_read_clear_word: assert property (
        (flags_read_clear && hw_sets == 32'h0000_0000) |=> (flags_word == 32'h0000_0000))
        else $error("flag word not cleared by its read");
    a_flags_write_ign: assert property (
        (wr_fire && wr_sel == SEL_FLAGS && !flags_read_clear && hw_sets == 32'h0000_0000)
            |=> $stable(flags_word))
        else $error("write changed the flag word");

endmodule

// *** logic/irq_summary.sv ***
// Summary interrupt status, mask and interrupt line of the buffer event block
`timescale 1ns/1ps
`include "buffer_event_defs.svh"

module irq_summary (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [31:0] hw_sets,
    input  wire logic [31:0] enables,
    input  wire logic        stat_write,
    input  wire logic        mask_write,
    input  wire logic [1:0]  write_bits,
    output logic [1:0]       status,
    output logic [1:0]       mask,
    output logic             irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic       irq_q;
    logic       irq_d;
    logic [1:0] raise;

    // Lower buffers feed bit 0, upper buffers bit 1; enable 0 blocks
    always_comb begin
        raise[0] = |(hw_sets[15:0] & enables[15:0]);
        raise[1] = |(hw_sets[31:16] & enables[31:16]);
        // Write one to clear, but a new raise in that cycle survives
        status_d = (status_q & ~(stat_write ? write_bits : 2'h0)) | raise;
        mask_d   = mask_write ? write_bits : mask_q;
        irq_d    = |(status_d & mask_d);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_q <= 2'h0;
            mask_q   <= 2'h0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= irq_d;
        end
    end

    assign status = status_q;
    assign mask   = mask_q;
    assign irq    = irq_q;

    a_lower_summary: assert property (
        (|(hw_sets[15:0] & enables[15:0])) |=> status_q[0])
        else $error("enabled lower buffer event missed summary bit");
    a_enable_gate: assert property (
        (!(|(hw_sets[31:16] & enables[31:16])) && !status_q[1]) |=> !status_q[1])
        else $error("disabled upper buffer event set summary bit");
    a_irq_level: assert property (
        irq_q == |(status_q & mask_q))
        else $error("interrupt line disagrees with status and mask");

endmodule

// *** logic/lane_event_flags.sv ***
// Sticky event flags and level mark detection for one data buffer
`timescale 1ns/1ps
`include "buffer_event_defs.svh"

module lane_event_flags #(
    parameter buffer_event_pkg::lane_t RESET_VAL = 8'h00
) (
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic                     cell_confirm,
    input  wire logic                     stamp_release,
    input  wire logic                     stamp_expire,
    input  wire logic                     no_space,
    input  wire logic                     no_data,
    input  wire buffer_event_pkg::count_t quadlet_count,
    input  wire buffer_event_pkg::count_t mark_lo_thresh,
    input  wire buffer_event_pkg::count_t mark_hi_thresh,
    input  wire logic                     mark_lo_above,
    input  wire logic                     mark_hi_above,
    input  wire logic                     read_clear,
    output logic [7:0]                    flags,
    output logic [7:0]                    hw_sets,
    output logic [1:0]                    mark_state
);
    import buffer_event_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    lane_t      flags_q;
    lane_t      flags_d;
    logic [1:0] mark_q;
    logic [1:0] mark_now;
    logic [1:0] mark_rise;
    lane_t      sets;

    // Level marks: direction bit picks rising above or falling below
    always_comb begin
        mark_now[1] = mark_hi_above ? (quadlet_count > mark_hi_thresh)
                                    : (quadlet_count < mark_hi_thresh);
        mark_now[0] = mark_lo_above ? (quadlet_count > mark_lo_thresh)
                                    : (quadlet_count < mark_lo_thresh);
        mark_rise   = mark_now & ~mark_q; // Only 0 to 1 counts
        sets                = 8'h00;
        sets[`BIT_CELL]     = cell_confirm;
        sets[`BIT_RELEASE]  = stamp_release;
        sets[`BIT_EXPIRE]   = stamp_expire;
        sets[`BIT_MARK_HI]  = mark_rise[1];
        sets[`BIT_MARK_LO]  = mark_rise[0];
        // Held levels re-set every cycle, so a read cannot hide them
        sets[`BIT_FULL]     = no_space;
        sets[`BIT_EMPTY]    = no_data;
        // Set wins over the read clear; reserved bit forced low
        flags_d = ((read_clear ? 8'h00 : flags_q) | sets) & `LANE_VALID;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags_q <= RESET_VAL;
            mark_q  <= 2'h0;
        end else begin
            flags_q <= flags_d;
            mark_q  <= mark_now;
        end
    end

    assign flags      = flags_q;
    assign hw_sets    = sets & `LANE_VALID;
    assign mark_state = mark_q;

    a_mark_rise_flag: assert property (
        mark_rise[1] |=> flags_q[`BIT_MARK_HI])
        else $error("level mark high rise did not set its flag");
    a_mark_no_resets: assert property (
        (mark_q[0] && mark_now[0] && read_clear && !sets[`BIT_MARK_LO])
            |=> !flags_q[`BIT_MARK_LO])
        else $error("steady level mark set its flag again");
    a_reserved_zero: assert property (
        flags_q[`BIT_RSVD] == 1'b0)
        else $error("reserved flag bit reads nonzero");
    a_set_beats_clear: assert property (
        (read_clear && cell_confirm) |=> flags_q[`BIT_CELL])
        else $error("cell confirm lost against read clear");
    a_clear_when_quiet: assert property (
        (read_clear && sets == 8'h00) |=> (flags_q == 8'h00))
        else $error("read did not clear the flags");
    a_full_reads_one: assert property (
        no_space |=> flags_q[`BIT_FULL])
        else $error("full flag low while buffer full");
    a_empty_reads_one: assert property (
        no_data |=> flags_q[`BIT_EMPTY])
        else $error("empty flag low while buffer empty");

endmodule
